// *** hw/tppc_counter.sv ***
// Purpose: Quadrature pulse counter channel with a classic Wishbone slave.
// Assumes: Phase inputs are synchronised here; all logic runs on CLOCK.
// Notes:   Writes take effect on the acknowledge edge; unmapped offsets read as zero.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module tppc_counter
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        PHASE_INPUT_A,
  input  wire logic        PHASE_INPUT_B,
  output logic             COUNT_EVENT_IRQ,
  output logic             COMPARE_MATCH_IRQ0,
  output logic             COMPARE_MATCH_IRQ1,
  output logic             DMA_REQ
);

  tppc_pkg::tppc_wb_req_t req;
  tppc_pkg::tppc_step_t   step;

  logic [1:0]  sync1_ff,  sync2_ff,  prev_ff;
  logic [1:0]  nxt_sync1, nxt_sync2, nxt_prev;
  logic        run_ff,    nxt_run;
  logic [1:0]  mode_ff,   nxt_mode;
  logic        cnt_ie_ff, nxt_cnt_ie;
  logic        cmp_ie_ff, nxt_cmp_ie;
  logic        dma_en_ff, nxt_dma_en;
  logic [15:0] match0_flag_ff,   nxt_match0_flag;
  logic [15:0] match1_flag_ff,   nxt_match1_flag;
  logic [15:0] cnt_ff,    nxt_cnt;
  logic [3:0]  flags_ff,  nxt_flags;
  logic [31:0] rdat_ff,   nxt_rdat;
  logic        ack_ff,    nxt_ack;
  logic        evt_ff,    nxt_evt;
  logic        m0_ff,     nxt_m0;
  logic        m1_ff,     nxt_m1;
  logic        dma_ff,    nxt_dma;
  tppc_pkg::tppc_guard_t guard_ff, nxt_guard;

  logic        wr_strobe;
  logic        clr_wr;
  logic        run_rise;
  logic [15:0] cnt_step;

  // Exact byte-address match; an offset that is not word aligned falls to the unmapped branch.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  always_comb
  begin
    req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I, adr: WB_ADR_I, dat: WB_DAT_I};
  end

  // Synchroniser: only the second stage and the previous-state copy are used.
  // The previous-state copy resets with the stages, so no stale history survives a reset.
  always_comb
  begin
    nxt_sync1 = {PHASE_INPUT_B, PHASE_INPUT_A};
    nxt_sync2 = sync1_ff;
    nxt_prev  = sync2_ff;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      prev_ff  <= 2'h0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  // Transition decode per mode.
  always_comb
  begin
    step      = '{up: 1'b0, down: 1'b0};
    nxt_guard = guard_ff;
    if (run_ff && (prev_ff != sync2_ff))
    begin
      case (mode_ff)
        tppc_pkg::TPPC_NORMAL:
        begin
          // A cleared guard blocks counting until a move from state 1 or 2 to state 0 re-arms it.
          if (prev_ff == 2'h2 && sync2_ff == 2'h3 && guard_ff == tppc_pkg::TPPC_ARMED)
            step.up = 1'b1;
          else if (prev_ff == 2'h1 && sync2_ff == 2'h3 && guard_ff == tppc_pkg::TPPC_ARMED)
            step.down = 1'b1;
          if (prev_ff == 2'h3 && sync2_ff == 2'h2)
            nxt_guard = tppc_pkg::TPPC_CLEARED;
          else if (prev_ff == 2'h3 && sync2_ff == 2'h1)
            nxt_guard = tppc_pkg::TPPC_CLEARED;
          if ((prev_ff == 2'h1 || prev_ff == 2'h2) && sync2_ff == 2'h0)
            nxt_guard = tppc_pkg::TPPC_ARMED;
        end
        tppc_pkg::TPPC_QUAD:
        begin
          case ({prev_ff, sync2_ff})
            4'hD, 4'h4, 4'h2, 4'hB: step.up   = 1'b1;
            4'hE, 4'h8, 4'h1, 4'h7: step.down = 1'b1;
            default:                step      = '{up: 1'b0, down: 1'b0};
          endcase
        end
        tppc_pkg::TPPC_DOUBLE:
        begin
          // A single phase edge flips the parity of the state, so every edge of either phase counts.
          // Both phases moving at once keeps the parity and is ignored, as it carries no direction.
          if ((^prev_ff) != (^sync2_ff))
            step.up = 1'b1;
        end
        default:
        begin
          step = '{up: 1'b0, down: 1'b0};
        end
      endcase
    end
  end

  // Writes land on the edge where the master sees ack, so an abandoned request changes nothing.
  assign wr_strobe = req.cyc && req.stb && req.we && ack_ff && req.sel[0];
  assign clr_wr    = wr_strobe && hit(req.adr, tppc_pkg::REG_RUN) && req.dat[tppc_pkg::CLR_BIT];
  assign run_rise  = wr_strobe && hit(req.adr, tppc_pkg::REG_RUN) && req.dat[tppc_pkg::RUN_BIT] && !run_ff;
  assign cnt_step  = step.up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;

  // Counter, flags and event outputs.
  always_comb
  begin
    nxt_cnt   = cnt_ff;
    nxt_flags = flags_ff;
    if (run_rise || clr_wr)
      nxt_cnt = tppc_pkg::CNT_INIT;
    else if (step.up || step.down)
      nxt_cnt = cnt_step;
    // Write-one clears first, so a same-cycle hardware set wins.
    if (wr_strobe && hit(req.adr, tppc_pkg::REG_FLAGS))
      nxt_flags = flags_ff & ~req.dat[3:0];
    if (step.up && cnt_ff == tppc_pkg::CNT_MAX)
      nxt_flags[tppc_pkg::FLG_OVF] = 1'b1;
    if (step.down && cnt_ff == tppc_pkg::CNT_MIN)
      nxt_flags[tppc_pkg::FLG_UDF] = 1'b1;
    if ((step.up || step.down) && cnt_step == match0_flag_ff)
      nxt_flags[tppc_pkg::FLG_MATCH0_FLAG] = 1'b1;
    if ((step.up || step.down) && cnt_step == match1_flag_ff)
      nxt_flags[tppc_pkg::FLG_MATCH1_FLAG] = 1'b1;
    nxt_evt = (step.up || step.down) && cnt_ie_ff;
    nxt_m0  = (step.up || step.down) && cnt_step == match0_flag_ff && cmp_ie_ff;
    nxt_m1  = (step.up || step.down) && cnt_step == match1_flag_ff && cmp_ie_ff;
    nxt_dma = (step.up || step.down) && cnt_ie_ff && dma_en_ff;
  end

  // Register writes and read data.
  always_comb
  begin
    nxt_run    = run_ff;
    nxt_mode   = mode_ff;
    nxt_cnt_ie = cnt_ie_ff;
    nxt_cmp_ie = cmp_ie_ff;
    nxt_dma_en = dma_en_ff;
    nxt_match0_flag   = match0_flag_ff;
    nxt_match1_flag   = match1_flag_ff;
    nxt_rdat   = 32'h0000_0000;
    nxt_ack    = req.cyc && req.stb && !ack_ff;
    if (wr_strobe)
    begin
      if (hit(req.adr, tppc_pkg::REG_RUN))
        nxt_run = req.dat[tppc_pkg::RUN_BIT];
      else if (hit(req.adr, tppc_pkg::REG_CTRL))
      begin
        nxt_mode   = req.dat[1:0];
        nxt_cnt_ie = req.dat[tppc_pkg::CNT_IRQ_BIT];
        nxt_cmp_ie = req.dat[tppc_pkg::CMP_IRQ_BIT];
      end
      else if (hit(req.adr, tppc_pkg::REG_DMA))
        nxt_dma_en = req.dat[tppc_pkg::DMA_EN_BIT];
    end
    if (wr_strobe && hit(req.adr, tppc_pkg::REG_MATCH0_FLAG))
      nxt_match0_flag = {req.sel[1] ? req.dat[15:8] : match0_flag_ff[15:8], req.dat[7:0]};
    if (wr_strobe && hit(req.adr, tppc_pkg::REG_MATCH1_FLAG))
      nxt_match1_flag = {req.sel[1] ? req.dat[15:8] : match1_flag_ff[15:8], req.dat[7:0]};
    if (req.cyc && req.stb && !req.we && !ack_ff)
    begin
      if (hit(req.adr, tppc_pkg::REG_RUN))
        nxt_rdat = {31'h0000_0000, run_ff};
      else if (hit(req.adr, tppc_pkg::REG_CTRL))
        nxt_rdat = {28'h000_0000, cmp_ie_ff, cnt_ie_ff, mode_ff};
      else if (hit(req.adr, tppc_pkg::REG_FLAGS))
        nxt_rdat = {28'h000_0000, flags_ff};
      else if (hit(req.adr, tppc_pkg::REG_MATCH0_FLAG))
        nxt_rdat = {16'h0000, match0_flag_ff};
      else if (hit(req.adr, tppc_pkg::REG_MATCH1_FLAG))
        nxt_rdat = {16'h0000, match1_flag_ff};
      else if (hit(req.adr, tppc_pkg::REG_COUNT))
        nxt_rdat = {16'h0000, cnt_ff};
      else if (hit(req.adr, tppc_pkg::REG_DMA))
        nxt_rdat = {29'h0000_0000, dma_en_ff, 2'h0};
      else
        nxt_rdat = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      run_ff    <= 1'b0;
      mode_ff   <= 2'h0;
      cnt_ie_ff <= 1'b0;
      cmp_ie_ff <= 1'b0;
      dma_en_ff <= 1'b0;
      match0_flag_ff   <= 16'h0000;
      match1_flag_ff   <= 16'h0000;
      cnt_ff    <= tppc_pkg::CNT_INIT;
      flags_ff  <= 4'h0;
      rdat_ff   <= 32'h0000_0000;
      ack_ff    <= 1'b0;
      evt_ff    <= 1'b0;
      m0_ff     <= 1'b0;
      m1_ff     <= 1'b0;
      dma_ff    <= 1'b0;
      guard_ff  <= tppc_pkg::TPPC_ARMED;
    end
    else
    begin
      run_ff    <= nxt_run;
      mode_ff   <= nxt_mode;
      cnt_ie_ff <= nxt_cnt_ie;
      cmp_ie_ff <= nxt_cmp_ie;
      dma_en_ff <= nxt_dma_en;
      match0_flag_ff   <= nxt_match0_flag;
      match1_flag_ff   <= nxt_match1_flag;
      cnt_ff    <= nxt_cnt;
      flags_ff  <= nxt_flags;
      rdat_ff   <= nxt_rdat;
      ack_ff    <= nxt_ack;
      evt_ff    <= nxt_evt;
      m0_ff     <= nxt_m0;
      m1_ff     <= nxt_m1;
      dma_ff    <= nxt_dma;
      guard_ff  <= nxt_guard;
    end
  end

  assign WB_DAT_O           = rdat_ff;
  assign WB_ACK_O           = ack_ff;
  assign COUNT_EVENT_IRQ    = evt_ff;
  assign COMPARE_MATCH_IRQ0 = m0_ff;
  assign COMPARE_MATCH_IRQ1 = m1_ff;
  assign DMA_REQ            = dma_ff;

  // Checks on events and DMA, stepping, wrapping and flags, grouped at the end of the module.
  a_dma_needs_irq: assert property (@(posedge CLOCK) disable iff (RST)
    DMA_REQ |-> COUNT_EVENT_IRQ)
    else $error("DMA request without count interrupt.");
  a_dma_follows_en: assert property (@(posedge CLOCK) disable iff (RST)
    ((step.up || step.down) && cnt_ie_ff && dma_en_ff) |=> DMA_REQ)
    else $error("DMA request missing.");
  a_evt_on_step: assert property (@(posedge CLOCK) disable iff (RST)
    ((step.up || step.down) && cnt_ie_ff) |=> COUNT_EVENT_IRQ)
    else $error("Count interrupt missing.");

  a_quad_step_up: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_QUAD && prev_ff == 2'h0 && sync2_ff == 2'h2 && !clr_wr && !run_rise)
    |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("Quadruple increment wrong.");
  a_quad_step_dn: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_QUAD && prev_ff == 2'h2 && sync2_ff == 2'h0 && !clr_wr && !run_rise)
    |=> cnt_ff == $past(cnt_ff) - 16'h0001)
    else $error("Quadruple decrement wrong.");
  a_double_step_up: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_DOUBLE && prev_ff != sync2_ff && (prev_ff ^ sync2_ff) != 2'h3
     && !clr_wr && !run_rise) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("Doubled increment missing.");
  a_double_no_dn: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_DOUBLE && !clr_wr && !run_rise)
    |=> (cnt_ff == $past(cnt_ff)) || (cnt_ff == $past(cnt_ff) + 16'h0001))
    else $error("Doubled mode decremented.");
  a_norm_step_up: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_NORMAL && guard_ff == tppc_pkg::TPPC_ARMED && prev_ff == 2'h2
     && sync2_ff == 2'h3 && !clr_wr && !run_rise) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("Normal increment missing.");
  a_norm_guard: assert property (@(posedge CLOCK) disable iff (RST)
    (run_ff && mode_ff == tppc_pkg::TPPC_NORMAL && guard_ff == tppc_pkg::TPPC_CLEARED && !clr_wr && !run_rise)
    |=> cnt_ff == $past(cnt_ff))
    else $error("Counted while guarded.");

  a_clear_reload: assert property (@(posedge CLOCK) disable iff (RST)
    clr_wr |=> cnt_ff == tppc_pkg::CNT_INIT)
    else $error("Clear did not reload.");
  a_ovf_wrap: assert property (@(posedge CLOCK) disable iff (RST)
    (step.up && cnt_ff == tppc_pkg::CNT_MAX && !clr_wr && !run_rise)
    |=> cnt_ff == tppc_pkg::CNT_MIN && flags_ff[tppc_pkg::FLG_OVF])
    else $error("Overflow wrap wrong.");
  a_udf_wrap: assert property (@(posedge CLOCK) disable iff (RST)
    (step.down && cnt_ff == tppc_pkg::CNT_MIN && !clr_wr && !run_rise)
    |=> cnt_ff == tppc_pkg::CNT_MAX && flags_ff[tppc_pkg::FLG_UDF])
    else $error("Underflow wrap wrong.");
  a_flag_sticky: assert property (@(posedge CLOCK) disable iff (RST)
    (flags_ff[tppc_pkg::FLG_OVF] && !(wr_strobe && req.adr == tppc_pkg::REG_FLAGS && req.dat[tppc_pkg::FLG_OVF]))
    |=> flags_ff[tppc_pkg::FLG_OVF])
    else $error("Flag dropped without write.");
  a_match0_flag: assert property (@(posedge CLOCK) disable iff (RST)
    ((step.up || step.down) && cnt_step == match0_flag_ff) |=> flags_ff[tppc_pkg::FLG_MATCH0_FLAG])
    else $error("Compare 0 flag missing.");
  a_match1_flag: assert property (@(posedge CLOCK) disable iff (RST)
    ((step.up || step.down) && cnt_step == match1_flag_ff) |=> flags_ff[tppc_pkg::FLG_MATCH1_FLAG])
    else $error("Compare 1 flag missing.");

endmodule

// *** hw/tppc_pkg.sv ***
// Purpose: Shared constants and types for the two-phase pulse counter.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes:   Register offsets are word aligned.
package tppc_pkg;

  localparam logic [7:0] REG_RUN    = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_MATCH0_FLAG   = 8'h0C;
  localparam logic [7:0] REG_MATCH1_FLAG   = 8'h10;
  localparam logic [7:0] REG_COUNT  = 8'h14;
  localparam logic [7:0] REG_DMA    = 8'h18;

  localparam int RUN_BIT      = 0;
  localparam int CLR_BIT      = 1;
  localparam int DMA_EN_BIT   = 2;
  localparam int CNT_IRQ_BIT  = 2;
  localparam int CMP_IRQ_BIT  = 3;
  localparam int FLG_MATCH0_FLAG     = 0;
  localparam int FLG_MATCH1_FLAG     = 1;
  localparam int FLG_OVF      = 2;
  localparam int FLG_UDF      = 3;

  localparam logic [15:0] CNT_INIT = 16'h7FFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_MIN  = 16'h0000;

  typedef enum logic [1:0]
  {
    TPPC_NORMAL = 2'h0,
    TPPC_QUAD   = 2'h1,
    TPPC_DOUBLE = 2'h2
  } tppc_mode_t;

  typedef enum logic [1:0]
  {
    TPPC_ARMED   = 2'h0,
    TPPC_CLEARED = 2'h1
  } tppc_guard_t;

  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } tppc_wb_req_t;

  typedef struct packed
  {
    logic        up;
    logic        down;
  } tppc_step_t;

endpackage

// *** test/tppc_counter_tb_top.sv ***
// Purpose: Self-checking bench for the two-phase pulse counter.
// Assumes: One Wishbone access at a time; the encoder starts in state 3.
// Notes:   The wrap test walks half the counter range, from 7FFF up to the wrap, so it dominates run time.
`timescale 1ns/1ps
module tppc_counter_tb_top;
  logic        clock;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        go;
  logic        up;
  logic        ph_a;
  logic        ph_b;
  logic        evt;
  logic        ci0;
  logic        ci1;
  logic        dma;
  int          error_cnt;
  int          n_tests;
  int          n_evt;
  int          n_dma;
  int          n_c0;
  int          n_c1;

  tppc_counter dut (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(4'hF),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PHASE_INPUT_A(ph_a),
    .PHASE_INPUT_B(ph_b), .COUNT_EVENT_IRQ(evt), .COMPARE_MATCH_IRQ0(ci0), .COMPARE_MATCH_IRQ1(ci1), .DMA_REQ(dma));

  tppc_encoder enc (.clk(clock), .rst(rst), .go(go), .dir_up(up), .phase_a(ph_a), .phase_b(ph_b));

  always #2 clock = ~clock;

  always @(posedge clock)
  begin
    n_evt += (evt === 1'b1);
    n_dma += (dma === 1'b1);
    n_c0 += (ci0 === 1'b1);
    n_c1 += (ci1 === 1'b1);
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request is held until ack is sampled high, then dropped for a cycle.
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    @(posedge clock);
    while (ack !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        error_cnt++;
        give_verdict();
      end
      @(posedge clock);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  task step(input logic u, input int n, input int gap);
    repeat (n)
    begin
      go <= 1'b1;
      up <= u;
      @(posedge clock);
      go <= 1'b0;
      repeat (gap) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask

  task t_regs;
    rc("count", tppc_pkg::REG_COUNT, 32'h7FFF);
    rc("flags", tppc_pkg::REG_FLAGS, 32'h0);
    rc("dma", tppc_pkg::REG_DMA, 32'h0);
    rc("unmapped", 8'h1C, 32'h0);
    wr(tppc_pkg::REG_COUNT, 32'h1234);
    rc("count ro", tppc_pkg::REG_COUNT, 32'h7FFF);
    $display("test regs done");
  endtask

  task t_quad;
    wr(tppc_pkg::REG_CTRL, 32'h5);
    wr(tppc_pkg::REG_DMA, 32'h4);
    wr(tppc_pkg::REG_RUN, 32'h1);
    n_evt = 0;
    n_dma = 0;
    step(1'b1, 4, 3);
    rc("quad up", tppc_pkg::REG_COUNT, 32'h8003);
    rc("quad reread", tppc_pkg::REG_COUNT, 32'h8003);
    step(1'b0, 4, 3);
    rc("quad down", tppc_pkg::REG_COUNT, 32'h7FFF);
    chk("events", n_evt, 32'h8);
    chk("dma reqs", n_dma, 32'h8);
    wr(tppc_pkg::REG_CTRL, 32'h1);
    step(1'b1, 1, 3);
    step(1'b0, 1, 3);
    chk("dma masked", n_dma, 32'h8);
    rc("dma reg", tppc_pkg::REG_DMA, 32'h4);
    $display("test quad done");
  endtask

  task t_norm;
    wr(tppc_pkg::REG_CTRL, 32'h0);
    step(1'b1, 3, 3);
    rc("norm partial", tppc_pkg::REG_COUNT, 32'h7FFF);
    step(1'b1, 1, 3);
    rc("norm up", tppc_pkg::REG_COUNT, 32'h8000);
    step(1'b0, 4, 3);
    rc("norm down", tppc_pkg::REG_COUNT, 32'h7FFF);
    $display("test normal done");
  endtask

  task t_dbl;
    wr(tppc_pkg::REG_CTRL, 32'h2);
    step(1'b1, 4, 3);
    step(1'b0, 4, 3);
    rc("double", tppc_pkg::REG_COUNT, 32'h8007);
    wr(tppc_pkg::REG_CTRL, 32'h3);
    step(1'b1, 1, 3);
    rc("no mode", tppc_pkg::REG_COUNT, 32'h8007);
    rc("ctrl", tppc_pkg::REG_CTRL, 32'h3);
    wr(tppc_pkg::REG_RUN, 32'h3);
    rc("clear", tppc_pkg::REG_COUNT, 32'h7FFF);
    $display("test double done");
  endtask

  task t_cmp;
    wr(tppc_pkg::REG_CTRL, 32'h9);
    wr(tppc_pkg::REG_MATCH0_FLAG, 32'h8001);
    wr(tppc_pkg::REG_MATCH1_FLAG, 32'h7FFE);
    wr(tppc_pkg::REG_FLAGS, 32'hF);
    n_c0 = 0;
    n_c1 = 0;
    step(1'b1, 2, 3);
    step(1'b0, 3, 3);
    rc("match flags", tppc_pkg::REG_FLAGS, 32'h3);
    chk("irq0", n_c0, 32'h1);
    chk("irq1", n_c1, 32'h1);
    wr(tppc_pkg::REG_FLAGS, 32'h1);
    rc("w1c one", tppc_pkg::REG_FLAGS, 32'h2);
    step(1'b1, 1, 3);
    $display("test compare done");
  endtask

  task t_wrap;
    wr(tppc_pkg::REG_CTRL, 32'h1);
    wr(tppc_pkg::REG_FLAGS, 32'hF);
    step(1'b1, 32769, 1);
    rc("overflow", tppc_pkg::REG_COUNT, 32'h0);
    rc("ovf flag", tppc_pkg::REG_FLAGS, 32'h5);
    step(1'b0, 1, 3);
    rc("underflow", tppc_pkg::REG_COUNT, 32'hFFFF);
    rc("udf flag", tppc_pkg::REG_FLAGS, 32'hD);
    wr(tppc_pkg::REG_FLAGS, 32'hF);
    rc("flags clr", tppc_pkg::REG_FLAGS, 32'h0);
    wr(tppc_pkg::REG_RUN, 32'h0);
    wr(tppc_pkg::REG_RUN, 32'h1);
    rc("restart", tppc_pkg::REG_COUNT, 32'h7FFF);
    $display("test wrap done");
  endtask

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    go = 1'b0;
    up = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_quad();
    t_norm();
    t_dbl();
    t_cmp();
    t_wrap();
    give_verdict();
  end
endmodule

// *** test/tppc_encoder.sv ***
// Purpose: Encoder model that drives the two phase inputs of the counter.
// Assumes: One quadrature step per clock on which go is high.
// Notes:   The pattern is Gray coded, so only one phase moves per step.
`timescale 1ns/1ps
module tppc_encoder
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic dir_up,
  output logic      phase_a,
  output logic      phase_b
);
  logic [1:0] idx_ff;
  logic [1:0] nxt_idx;

  always_comb
  begin
    nxt_idx = idx_ff;
    if (go)
      nxt_idx = dir_up ? idx_ff + 2'h1 : idx_ff - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      idx_ff <= 2'h0;
    else
      idx_ff <= nxt_idx;
  end

  // Forward order visits states 3, 1, 0, 2 with phase B as the high bit.
  always_comb
  begin
    case (idx_ff)
      2'h0:    {phase_b, phase_a} = 2'h3;
      2'h1:    {phase_b, phase_a} = 2'h1;
      2'h2:    {phase_b, phase_a} = 2'h0;
      default: {phase_b, phase_a} = 2'h2;
    endcase
  end
endmodule
